//--- rtl/twoi_cfg.svh
// offsets, field positions, reset values and timing counts of the typewriter output host
`ifndef TWOI_CFG_SVH
`define TWOI_CFG_SVH

`define TWOI_ADDR_W 12
`define TWOI_CODE_W 8
`define TWOI_FIFO_DEPTH 32
`define TWOI_CNT_W 6

`define TWOI_CTRL_OFS 12'h000
`define TWOI_STAT_OFS 12'h004
`define TWOI_DATA_OFS 12'h008
`define TWOI_LAST_OFS 12'h00c
`define TWOI_SENT_OFS 12'h010

`define TWOI_CTRL_EN_BIT 0
`define TWOI_CTRL_CLR_BIT 1
`define TWOI_CTRL_RST 1'h0

`define TWOI_STAT_CNT_LSB 0
`define TWOI_STAT_RDY_BIT 8
`define TWOI_STAT_ACK_BIT 9
`define TWOI_STAT_IDLE_BIT 10

`define TWOI_LAST_KIND_LSB 8

`define TWOI_FN_SPACE 8'h0f
`define TWOI_FN_BKSP 8'h1f
`define TWOI_FN_LC 8'h2f
`define TWOI_FN_LOCK 8'h3f
`define TWOI_FN_TAB 8'h4f
`define TWOI_FN_CR 8'h5f
`define TWOI_FN_UC 8'h6f
`define TWOI_FN_UNLOCK 8'h7f

`define TWOI_CLK_NS 50
`define TWOI_SETUP_NS 1000
`define TWOI_SETUP_CYC ((`TWOI_SETUP_NS + `TWOI_CLK_NS - 1) / `TWOI_CLK_NS)
`define TWOI_SETUP_W 5

`endif

//--- rtl/twoi_pkg.sv
// types shared by the typewriter output host
package twoi_pkg;
   typedef enum logic [3:0] {
      K_CHAR, K_SPACE, K_BKSP, K_TAB, K_CR, K_UC, K_LC, K_LOCK, K_UNLOCK
   } twoi_kind_t;

   typedef enum logic [2:0] {
      ST_IDLE, ST_SETUP, ST_WAIT_FALL, ST_WAIT_RISE
   } twoi_st_t;

   typedef struct packed {
      twoi_kind_t kind;
      logic [7:0] code;
   } twoi_sent_t;
endpackage

//--- rtl/twoi_fifo.sv
// parameterised fifo between the register bus and the code handshake
`timescale 1ns/1ps
module twoi_fifo #(
   parameter int W = 8,
   parameter int D = 32
) (
   input wire logic clk, // clock
   input wire logic rst_n, // async reset, low
   input wire logic in_valid, // push request
   output logic in_ready, // room left
   input wire logic [W-1:0] in_data, // pushed word
   output logic out_valid, // word available
   input wire logic out_ready, // pop request
   output logic [W-1:0] out_data, // head word
   output logic [$clog2(D):0] count // words held
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW-1:0] wr_reg;
   logic [AW-1:0] rd_reg;
   logic [AW:0] cnt_reg;
   logic push;
   logic pop;

   assign in_ready = (cnt_reg != (AW+1)'(D));
   assign out_valid = (cnt_reg != '0);
   assign out_data = mem[rd_reg];
   assign count = cnt_reg;
   assign push = in_valid & in_ready;
   assign pop = out_ready & out_valid;

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_reg] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
      end else begin
         if (push) begin
            wr_reg <= (wr_reg == AW'(D-1)) ? '0 : wr_reg + 1'b1;
         end
         if (pop) begin
            rd_reg <= (rd_reg == AW'(D-1)) ? '0 : rd_reg + 1'b1;
         end
         if (push && !pop) begin
            cnt_reg <= cnt_reg + 1'b1;
         end else if (pop && !push) begin
            cnt_reg <= cnt_reg - 1'b1;
         end
      end
   end
endmodule

//--- rtl/twoi_host.sv
// host end that feeds 8-bit codes to the typewriter output interface
// How it works
// - host puts the code on bits 0..7 before raising word-ready
// - on rising ack the host supplies the next code
// - function codes: 0f 1f 4f 5f 6f 2f 3f 7f as listed
// - a test fixture may replace the host and show input buffer
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "twoi_cfg.svh"
module twoi_host (
   input wire logic pclk, // bus clock, 20 MHz
   input wire logic presetn, // async reset, low
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [`TWOI_ADDR_W-1:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error
   output logic [`TWOI_CODE_W-1:0] out_code, // code bits to interface
   output logic out_word_ready, // word-ready to interface
   input wire logic out_word_ack // acknowledge from interface
);
   function automatic logic is_mapped(input logic [`TWOI_ADDR_W-1:0] a);
      is_mapped = (a == `TWOI_CTRL_OFS) || (a == `TWOI_STAT_OFS) ||
         (a == `TWOI_DATA_OFS) || (a == `TWOI_LAST_OFS) || (a == `TWOI_SENT_OFS);
   endfunction

   function automatic twoi_pkg::twoi_kind_t fn_kind(input logic [7:0] c);
      case (c)
         `TWOI_FN_SPACE: fn_kind = twoi_pkg::K_SPACE;
         `TWOI_FN_BKSP: fn_kind = twoi_pkg::K_BKSP;
         `TWOI_FN_TAB: fn_kind = twoi_pkg::K_TAB;
         `TWOI_FN_CR: fn_kind = twoi_pkg::K_CR;
         `TWOI_FN_UC: fn_kind = twoi_pkg::K_UC;
         `TWOI_FN_LC: fn_kind = twoi_pkg::K_LC;
         `TWOI_FN_LOCK: fn_kind = twoi_pkg::K_LOCK;
         `TWOI_FN_UNLOCK: fn_kind = twoi_pkg::K_UNLOCK;
         default: fn_kind = twoi_pkg::K_CHAR;
      endcase
   endfunction

   logic en_reg;
   logic [15:0] sent_reg;
   twoi_pkg::twoi_sent_t last_reg;
   twoi_pkg::twoi_st_t st_reg;
   logic [`TWOI_SETUP_W-1:0] cnt_reg;
   logic [`TWOI_CODE_W-1:0] code_reg;
   logic rdy_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic [31:0] prdata_reg;
   logic [31:0] rd_mux;
   logic acc;
   logic data_wr;
   logic can_ans;
   logic fire;
   logic f_in_ready;
   logic f_out_valid;
   logic f_pop;
   logic [`TWOI_CODE_W-1:0] f_data;
   logic [`TWOI_CNT_W-1:0] f_count;

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign out_code = code_reg;
   assign out_word_ready = rdy_reg;

   // a data write is held in its access phase while the fifo is full
   assign acc = psel & penable & ~pready_reg;
   assign data_wr = pwrite && (paddr == `TWOI_DATA_OFS);
   assign can_ans = ~data_wr | f_in_ready;
   assign fire = psel & penable & pready_reg;
   assign f_pop = (st_reg == twoi_pkg::ST_IDLE) & en_reg & f_out_valid;

   twoi_fifo #(
      .W(`TWOI_CODE_W),
      .D(`TWOI_FIFO_DEPTH)
   ) u_fifo (
      .clk(pclk),
      .rst_n(presetn),
      .in_valid(fire & data_wr),
      .in_ready(f_in_ready),
      .in_data(pwdata[`TWOI_CODE_W-1:0]),
      .out_valid(f_out_valid),
      .out_ready(f_pop),
      .out_data(f_data),
      .count(f_count)
   );

   always_comb begin
      rd_mux = 32'h0000_0000;
      case (paddr)
         `TWOI_CTRL_OFS: rd_mux[`TWOI_CTRL_EN_BIT] = en_reg;
         `TWOI_STAT_OFS: begin
            rd_mux[`TWOI_STAT_CNT_LSB +: `TWOI_CNT_W] = f_count;
            rd_mux[`TWOI_STAT_RDY_BIT] = rdy_reg;
            rd_mux[`TWOI_STAT_ACK_BIT] = out_word_ack;
            rd_mux[`TWOI_STAT_IDLE_BIT] = (st_reg == twoi_pkg::ST_IDLE) & ~f_out_valid;
         end
         `TWOI_LAST_OFS: begin
            rd_mux[7:0] = last_reg.code;
            rd_mux[`TWOI_LAST_KIND_LSB +: 4] = last_reg.kind;
         end
         `TWOI_SENT_OFS: rd_mux[15:0] = sent_reg;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
      end else begin
         pready_reg <= acc & can_ans;
         pslverr_reg <= acc & can_ans & ~is_mapped(paddr);
         prdata_reg <= (acc & can_ans & ~pwrite) ? rd_mux : 32'h0000_0000;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_reg <= `TWOI_CTRL_RST;
      end else if (fire && pwrite && paddr == `TWOI_CTRL_OFS) begin
         en_reg <= pwdata[`TWOI_CTRL_EN_BIT];
      end
   end

   // code handshake; ready low time equals the setup wait plus one cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= twoi_pkg::ST_IDLE;
         cnt_reg <= '0;
         code_reg <= 8'h00;
         rdy_reg <= 1'b0;
      end else begin
         case (st_reg)
            twoi_pkg::ST_IDLE: begin
               if (f_pop) begin
                  code_reg <= f_data;
                  cnt_reg <= `TWOI_SETUP_W'(`TWOI_SETUP_CYC - 1);
                  st_reg <= twoi_pkg::ST_SETUP;
               end
            end
            twoi_pkg::ST_SETUP: begin
               if (cnt_reg == '0) begin
                  rdy_reg <= 1'b1;
                  st_reg <= twoi_pkg::ST_WAIT_FALL;
               end else begin
                  cnt_reg <= cnt_reg - 1'b1;
               end
            end
            twoi_pkg::ST_WAIT_FALL: begin
               // ack must first drop to show this word was loaded
               if (!out_word_ack) begin
                  st_reg <= twoi_pkg::ST_WAIT_RISE;
               end
            end
            twoi_pkg::ST_WAIT_RISE: begin
               if (out_word_ack) begin
                  rdy_reg <= 1'b0;
                  st_reg <= twoi_pkg::ST_IDLE;
               end
            end
            default: st_reg <= twoi_pkg::ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_reg <= '0;
      end else if (f_pop) begin
         last_reg.code <= f_data;
         last_reg.kind <= fn_kind(f_data);
      end
   end

   // counter clear and a completed word in one cycle: the count still advances
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sent_reg <= 16'h0000;
      end else if (st_reg == twoi_pkg::ST_WAIT_RISE && out_word_ack) begin
         sent_reg <= sent_reg + 16'h0001;
      end else if (fire && pwrite && paddr == `TWOI_CTRL_OFS && pwdata[`TWOI_CTRL_CLR_BIT]) begin
         sent_reg <= 16'h0000;
      end
   end

   property p_code_setup;
      @(posedge pclk) disable iff (!presetn)
      $rose(out_word_ready) |-> $stable(out_code) && $past(st_reg) == twoi_pkg::ST_SETUP;
   endproperty
   a_code_setup: assert property (p_code_setup) else $error("code not set before ready");

   property p_code_held;
      @(posedge pclk) disable iff (!presetn)
      out_word_ready && $past(out_word_ready) |-> $stable(out_code);
   endproperty
   a_code_held: assert property (p_code_held) else $error("code changed while ready high");

   property p_ack_release;
      @(posedge pclk) disable iff (!presetn)
      (st_reg == twoi_pkg::ST_WAIT_RISE && out_word_ack) |=> !out_word_ready ##1 !out_word_ready;
   endproperty
   a_ack_release: assert property (p_ack_release) else $error("ready not dropped on ack");

   property p_next_code;
      @(posedge pclk) disable iff (!presetn)
      $fell(out_word_ready) && f_out_valid && en_reg |=> st_reg == twoi_pkg::ST_SETUP;
   endproperty
   a_next_code: assert property (p_next_code) else $error("next code not supplied");

   property p_kind;
      @(posedge pclk) disable iff (!presetn)
      f_pop && f_data == `TWOI_FN_CR |=> last_reg.kind == twoi_pkg::K_CR;
   endproperty
   a_kind: assert property (p_kind) else $error("carrier return code misclassified");

   property p_full_stall;
      @(posedge pclk) disable iff (!presetn)
      acc && data_wr && !f_in_ready |=> !pready;
   endproperty
   a_full_stall: assert property (p_full_stall) else $error("write answered into full fifo");

   c_word: cover property (@(posedge pclk) disable iff (!presetn) $fell(out_word_ready));
   c_full: cover property (@(posedge pclk) disable iff (!presetn) acc && data_wr && !f_in_ready);
   c_space: cover property (@(posedge pclk) disable iff (!presetn)
      f_pop && f_data == `TWOI_FN_SPACE);
endmodule

//--- verif/twoi_dev_model.sv
// behavioural model of the typewriter output interface seen by the host
`timescale 1ns/1ps
module twoi_dev_model #(
   parameter int SETTLE = 100,
   parameter int MINW = 100,
   parameter int BUSY = 200
) (
   input wire logic pclk, // bus clock
   input wire logic presetn, // async reset, low
   input wire logic [7:0] code, // code bits from host
   input wire logic ready, // word-ready from host
   output logic ack // acknowledge to host
);
   logic [7:0] log_q [0:127];
   logic [6:0] mag_q [0:127];
   logic [6:0] cont_q [0:127];
   int n;
   int self_n;
   logic upper;
   logic self_ack;
   // lines r1 r2 r2a r5 t1 t2 ck; only a few rows are modelled, the rest select none
   function automatic logic [6:0] magnet_lines(input logic [7:0] c);
      case (c)
         8'h1a: magnet_lines = 7'h5b;
         8'h32: magnet_lines = 7'h51;
         8'h80: magnet_lines = 7'h76;
         default: magnet_lines = 7'h00;
      endcase
   endfunction
   initial begin
      ack = 1'b0;
      n = 0;
      self_n = 0;
      upper = 1'b0;
   end
   always begin
      @(posedge pclk iff (ready === 1'b1 && presetn === 1'b1));
      // settle time before the load pulse
      repeat (SETTLE) @(posedge pclk);
      log_q[n] = code;
      mag_q[n] = magnet_lines(code);
      // contacts read closed high; fifth row normally open, others normally closed
      cont_q[n] = magnet_lines(code) ^ 7'h77;
      n++;
      ack <= 1'b0;
      self_ack = (code == 8'h3f) || (code == 8'h7f) || (code == 8'h2f && !upper) ||
                 (code == 8'h6f && upper);
      if (code == 8'h6f) upper = 1'b1;
      if (code == 8'h2f) upper = 1'b0;
      repeat (MINW) @(posedge pclk);
      // print cycle shortened; no busy follows a redundant shift, a lock or an unlock
      if (!self_ack) repeat (BUSY) @(posedge pclk);
      else self_n++;
      ack <= 1'b1;
      @(posedge pclk iff ready === 1'b0);
   end
endmodule

//--- verif/twoi_host_tb.sv
// self-checking bench for the typewriter output host
`timescale 1ns/1ps
`include "twoi_cfg.svh"
module twoi_host_tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic pready, pslverr, out_word_ready, out_word_ack, er;
   logic [7:0] out_code;
   int err_count = 0;
   int samples_checked = 0;
   int cyc = 0;
   logic [7:0] seq [0:8] = '{8'h1a, 8'h0f, 8'h2f, 8'h6f, 8'h3f, 8'h7f, 8'h5f, 8'h1f, 8'h4f};
   always #25 pclk = ~pclk;
   twoi_host uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .out_code(out_code), .out_word_ready(out_word_ready),
      .out_word_ack(out_word_ack));
   twoi_dev_model dev (.pclk(pclk), .presetn(presetn), .code(out_code),
      .ready(out_word_ready), .ack(out_word_ack));
   task report_and_stop;
      if (err_count == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // whole run needs about 31k cycles
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 60000) begin
         err_count++;
         report_and_stop();
      end
   end
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // polls the completed-word counter; the global limit ends a hang
   task wait_sent(input logic [15:0] n);
      do apb(1'b0, `TWOI_SENT_OFS, 32'h0); while (rd[15:0] !== n);
   endtask
   task t_reset;
      apb(1'b0, `TWOI_CTRL_OFS, 32'h0);
      chk(rd, 32'h00000000);
      apb(1'b0, `TWOI_STAT_OFS, 32'h0);
      chk(rd, 32'h00000400);
      apb(1'b0, 12'h020, 32'h0);
      chk({31'h0, er}, 32'h00000001);
      chk(rd, 32'h00000000);
   endtask
   task t_stream;
      apb(1'b1, `TWOI_CTRL_OFS, 32'h1);
      for (int i = 0; i < 9; i++) apb(1'b1, `TWOI_DATA_OFS, {24'h0, seq[i]});
      wait_sent(16'd9);
      for (int i = 0; i < 9; i++) chk({24'h0, dev.log_q[i]}, {24'h0, seq[i]});
      chk(dev.self_n, 32'd3);
      chk({25'h0, dev.mag_q[0]}, 32'h0000005b);
      chk({25'h0, dev.cont_q[0]}, 32'h0000002c);
      apb(1'b0, `TWOI_LAST_OFS, 32'h0);
      chk(rd, 32'h0000034f);
   endtask
   // fill the fifo while stopped, then drain it through the slow far side
   task t_fifo;
      apb(1'b1, `TWOI_CTRL_OFS, 32'h2);
      apb(1'b0, `TWOI_SENT_OFS, 32'h0);
      chk(rd, 32'h00000000);
      for (int i = 0; i < 32; i++) apb(1'b1, `TWOI_DATA_OFS, 32'h000000c0 + i);
      apb(1'b0, `TWOI_STAT_OFS, 32'h0);
      chk(rd, 32'h00000220);
      apb(1'b1, `TWOI_CTRL_OFS, 32'h1);
      wait_sent(16'd32);
      for (int i = 0; i < 32; i++) chk({24'h0, dev.log_q[9 + i]}, 32'h000000c0 + i);
      apb(1'b0, `TWOI_LAST_OFS, 32'h0);
      chk(rd, 32'h000000df);
      apb(1'b0, `TWOI_STAT_OFS, 32'h0);
      chk(rd, 32'h00000600);
   endtask
   // overfill while the first word prints: the extra write waits for a free slot
   task t_full;
      int c0;
      for (int i = 0; i < 33; i++) apb(1'b1, `TWOI_DATA_OFS, 32'h00000040 + i);
      apb(1'b0, `TWOI_STAT_OFS, 32'h0);
      chk(rd & 32'h0000013f, 32'h00000120);
      c0 = cyc;
      apb(1'b1, `TWOI_DATA_OFS, 32'h00000061);
      chk({31'h0, (cyc - c0) > 20}, 32'h00000001);
      wait_sent(16'd66);
      for (int i = 0; i < 34; i++) chk({24'h0, dev.log_q[41 + i]}, 32'h00000040 + i);
   endtask
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_stream();
      t_fifo();
      t_full();
      report_and_stop();
   end
endmodule
